// ==== hw/crs_pkg.sv ====
// Constants, register map and state types of the clock and reset supervisor
// Operation
// [R1] Withhold PLL clock until start-up delay ends
// [R2] Set PLL lock flag at operating frequency
// [R3] Clock control bits 7:2 read zero
// [R4] Clock-out enable bit drives clock pin
// [R5] Slow select divides CPU clock by 32
// [R6] Clock control bits read/write, cleared on reset
// [R7] Trim register resets to FFh, monotonic code
// [R8] Software loads trim value after every reset
// [R9] Three reset sources, pin low during delay
// [R10] Vector fetch from top-of-memory locations
// [R11] Active phase, 256-cycle delay, then fetch
// [R12] Vector fetch lasts exactly two cycles
// [R13] PLL start-up delay added when enabled
// [R14] External reset pulse caught without clock
// [R15] Reset pin is input and open-drain output
// [R16] Watchdog underflow drives pin low minimum width
// [R17] Pin held low while low-voltage reset
// [R18] Low-voltage reset clears watchdog reset flag
// [R19] Warning flag is live, read-only, unlatched
// [R20] Warning works only with detector enabled
// [R21] Interrupt on each warning threshold crossing
// [R22] Threshold selectable; warning follows selection
// [R23] Bit 3 is hardware-owned PLL lock flag
// [R24] Bit 2 low-voltage flag, write zero clears
// [R25] Bit 0 enables interrupt, cleared on entry
// [R26] Interrupt wakes from wait, register frozen halt
// [R27] Divider switch gives no truncated pulses
package crs_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ        = 32'hA;
   localparam int DLY_CYC        = 32'h100;
   localparam int FETCH_CYC      = 32'h2;
   localparam int WDG_PULSE_NS   = 32'h7530;
   localparam int PLL_STARTUP_NS = 32'h186A0;
   // Least times, so round up
   localparam int WDG_CYC = (WDG_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int PLL_CYC = (PLL_STARTUP_NS * CLK_MHZ + 999) / 1000;
   localparam int SLOW_DIV = 32'h20;

   // ----------------------------------------
   // Register indices, byte address is 4x
   // ----------------------------------------
   localparam logic [5:0] IDX_MCC  = 6'h38;
   localparam logic [5:0] IDX_TRIM = 6'h39;
   localparam logic [5:0] IDX_SIR  = 6'h3A;
   localparam logic [5:0] IDX_RSF  = 6'h3B;

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int MCC_CKO_BIT   = 1;
   localparam int MCC_SLOW_BIT  = 0;
   localparam int SIR_LOCK_BIT  = 3;
   localparam int SIR_LOW_VOLTAGE_RESET_FLAG_BIT = 2;
   localparam int SIR_VOLTAGE_WARNING_FLAG_BIT  = 1;
   localparam int SIR_VOLTAGE_WARNING_IRQ_ENABLE_BIT = 0;
   localparam int RSF_WDG_BIT   = 0;
   localparam logic [7:0]  TRIM_RST = 8'hFF;
   localparam logic [15:0] VEC_ADDR = 16'hFFFE;

   typedef enum logic [2:0] {ST_RUN, ST_ACT, ST_DELAY, ST_PLL, ST_FETCH} crs_state_t;
   typedef enum logic [1:0] {SRC_EXT, SRC_LVD, SRC_WDG} crs_src_t;

endpackage

// ==== hw/crs_slow_div.sv ====
// CPU clock enable generator with glitch-free slow mode switch
`timescale 1ns/100ps
module crs_slow_div #(
   parameter int DIV = 32
) (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   // Mode and enable
   input  wire logic slow_sel_i,
   output logic      cpu_en_o
);

   // Counter is eight bits wide, and a divide below two has no slow period
   if (DIV < 2 || DIV > 256) begin : g_div_check
      $error("crs_slow_div: DIV out of range");
   end

   logic [7:0] cnt_q;
   logic       mode_q;
   logic       wrap;

   assign wrap = (cnt_q == 8'(DIV - 1));

   // Mode changes only at the period boundary so no pulse is cut short
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cnt_q    <= 8'h00;
         mode_q   <= 1'b0;
         cpu_en_o <= 1'b1;
      end else begin
         cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
         if (wrap) begin
            mode_q <= slow_sel_i; // see [R27]
         end
         cpu_en_o <= mode_q ? wrap : 1'b1; // see [R5]
      end
   end

endmodule

// ==== hw/crs_supervisor.sv ====
// Clock control, reset sequencing and supply supervision with APB registers
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
module crs_supervisor (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Reset pin, open drain
   input  wire logic        rst_pin_i,
   output logic             rst_pin_o,
   output logic             rst_pin_oe_o,
   // Reset sources and configuration options
   input  wire logic        lvd_rst_i,
   input  wire logic        wdg_underflow_i,
   input  wire logic        pll_en_opt_i,
   input  wire logic        lvd_en_opt_i,
   input  wire logic [1:0]  lvd_level_i,
   // Analog status
   input  wire logic        pll_lock_i,
   input  wire logic        avd_cmp_i,
   // Power modes and interrupt handshake
   input  wire logic        halt_i,
   input  wire logic        wake_i,
   input  wire logic        irq_ack_i,
   // Core side
   output logic             core_rst_n_o,
   output logic             vec_fetch_o,
   output logic [15:0]      vec_addr_o,
   output logic             cpu_clk_en_o,
   output logic             pll_clk_en_o,
   output logic             clk_out_en_o,
   output logic [7:0]       trim_code_o,
   output logic [1:0]       lvd_thresh_o,
   output logic [1:0]       avd_thresh_o,
   output logic             avd_irq_o,
   output logic             avd_wake_o
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   crs_pkg::crs_state_t state_q;
   crs_pkg::crs_state_t state_d;
   crs_pkg::crs_src_t   src_q;
   crs_pkg::crs_src_t   src_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] pll_cnt_q;
   logic        ext_catch_q;
   logic        ext_m_q;
   logic        ext_s_q;
   logic        pin_m_q;
   logic        pin_s_q;
   logic        lvd_m_q;
   logic        lvd_s_q;
   logic        lock_m_q;
   logic        lock_s_q;
   logic        avd_m_q;
   logic        avd_s_q;
   logic        slow_sel_q;
   logic        lock_q;
   logic        low_voltage_reset_flag_q;
   logic        voltage_warning_flag_q;
   logic        voltage_warning_irq_enable_q;
   logic        watchdog_reset_flag_q;
   logic        pll_start;
   logic        in_reset;
   logic        wr_en;
   logic        rd_hit;
   logic [5:0]  idx;
   logic [7:0]  rd_byte;

   assign in_reset = (state_q != crs_pkg::ST_RUN);
   assign idx      = paddr[7:2];

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------

   // Low pulse on the pin is caught without a clock, so halt cannot miss it
   always_ff @(posedge core_clk_i or negedge rst_pin_i) begin
      if (!rst_pin_i) begin
         ext_catch_q <= 1'b1; // see [R14]
      end else if (!rst_n_i || in_reset) begin
         ext_catch_q <= 1'b0;
      end
   end

   // Catch chain is flushed in reset so our own pin drive never retriggers
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || in_reset) begin
         ext_m_q <= 1'b0;
         ext_s_q <= 1'b0;
      end else begin
         ext_m_q <= ext_catch_q;
         ext_s_q <= ext_m_q;
      end
   end

   // Two flip-flops for the pin, low-voltage, lock and warning comparator levels
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pin_m_q  <= 1'b1;
         pin_s_q  <= 1'b1;
         lvd_m_q  <= 1'b0;
         lvd_s_q  <= 1'b0;
         lock_m_q <= 1'b0;
         lock_s_q <= 1'b0;
         avd_m_q  <= 1'b0;
         avd_s_q  <= 1'b0;
      end else begin
         pin_m_q  <= rst_pin_i; // see [R15]
         pin_s_q  <= pin_m_q;
         lvd_m_q  <= lvd_rst_i & lvd_en_opt_i;
         lvd_s_q  <= lvd_m_q;
         lock_m_q <= pll_lock_i;
         lock_s_q <= lock_m_q;
         avd_m_q  <= avd_cmp_i;
         avd_s_q  <= avd_m_q;
      end
   end

   // ----------------------------------------
   // Reset sequencer
   // ----------------------------------------

   // Next state; low voltage preempts every other phase
   always_comb begin
      state_d = state_q;
      src_d   = src_q;
      cnt_d   = cnt_q + 16'h0001;
      unique case (state_q)
         crs_pkg::ST_RUN: begin
            cnt_d = 16'h0000;
            if (wdg_underflow_i) begin
               state_d = crs_pkg::ST_ACT; // see [R9]
               src_d   = crs_pkg::SRC_WDG;
            end else if (ext_s_q) begin
               state_d = crs_pkg::ST_ACT;
               src_d   = crs_pkg::SRC_EXT;
            end
         end
         crs_pkg::ST_ACT: begin
            if ((src_q == crs_pkg::SRC_LVD && !lvd_s_q) ||
                (src_q == crs_pkg::SRC_WDG && cnt_q == 16'(crs_pkg::WDG_CYC - 1)) ||
                (src_q == crs_pkg::SRC_EXT && pin_s_q)) begin
               state_d = crs_pkg::ST_DELAY; // see [R11]
               cnt_d   = 16'h0000;
            end
         end
         crs_pkg::ST_DELAY: begin
            if (cnt_q == 16'(crs_pkg::DLY_CYC - 1)) begin
               state_d = pll_en_opt_i ? crs_pkg::ST_PLL : crs_pkg::ST_FETCH; // see [R13]
               cnt_d   = 16'h0000;
            end
         end
         crs_pkg::ST_PLL: begin
            // Leave in the cycle the PLL clock is released, so the wait is exactly the start-up delay
            if (pll_clk_en_o || pll_cnt_q == 16'(crs_pkg::PLL_CYC - 1)) begin
               state_d = crs_pkg::ST_FETCH;
               cnt_d   = 16'h0000;
            end
         end
         crs_pkg::ST_FETCH: begin
            if (cnt_q == 16'(crs_pkg::FETCH_CYC - 1)) begin
               state_d = crs_pkg::ST_RUN; // see [R12]
            end
         end
         default: begin
            state_d = crs_pkg::ST_DELAY;
         end
      endcase
      if (lvd_s_q && !(state_q == crs_pkg::ST_ACT && src_q == crs_pkg::SRC_LVD)) begin
         state_d = crs_pkg::ST_ACT; // see [R18]
         src_d   = crs_pkg::SRC_LVD;
         cnt_d   = 16'h0000;
      end
   end

   // Power-up enters the delay phase directly
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_q <= crs_pkg::ST_DELAY;
         src_q   <= crs_pkg::SRC_EXT;
         cnt_q   <= 16'h0000;
      end else begin
         state_q <= state_d;
         src_q   <= src_d;
         cnt_q   <= cnt_d;
      end
   end

   // Outputs registered from next state, so they line up with state_q
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rst_pin_oe_o <= 1'b1;
         rst_pin_o    <= 1'b0;
         core_rst_n_o <= 1'b0;
         vec_fetch_o  <= 1'b0;
         vec_addr_o   <= crs_pkg::VEC_ADDR;
      end else begin
         // External source holds the pin itself; driving it would hide release
         rst_pin_oe_o <= (state_d == crs_pkg::ST_DELAY) ||
                         (state_d == crs_pkg::ST_ACT && src_d != crs_pkg::SRC_EXT); // see [R9] [R16] [R17]
         rst_pin_o    <= 1'b0; // see [R15]
         core_rst_n_o <= (state_d == crs_pkg::ST_RUN);
         vec_fetch_o  <= (state_d == crs_pkg::ST_FETCH);
         vec_addr_o   <= crs_pkg::VEC_ADDR | {15'h0000, cnt_d[0]}; // see [R10]
      end
   end

   // ----------------------------------------
   // PLL start-up gating
   // ----------------------------------------
   assign pll_start = pll_en_opt_i &&
                      ((state_q == crs_pkg::ST_DELAY && state_d == crs_pkg::ST_PLL) ||
                       (state_q == crs_pkg::ST_RUN && wake_i));

   // Clock is withheld for the whole start-up delay on each start
   always_ff @(posedge core_clk_i) begin
      // Only the phases before the PLL wait and a wake in run restart it; fetch must keep the released clock
      if (!rst_n_i || pll_start || state_q == crs_pkg::ST_ACT || state_q == crs_pkg::ST_DELAY) begin
         pll_cnt_q    <= 16'h0000;
         pll_clk_en_o <= 1'b0; // see [R1]
      end else if (!pll_clk_en_o) begin
         pll_cnt_q    <= pll_cnt_q + 16'h0001;
         pll_clk_en_o <= (pll_cnt_q == 16'(crs_pkg::PLL_CYC - 1));
      end
   end

   // Lock flag owned by hardware alone
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= pll_en_opt_i & pll_clk_en_o & lock_s_q; // see [R2] [R23]
      end
   end

   // ----------------------------------------
   // Clock control and trim registers
   // ----------------------------------------
   assign wr_en = psel & penable & pready & pwrite;

   // Cleared by every reset phase, not only power-up
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || in_reset) begin
         slow_sel_q   <= 1'b0; // see [R6]
         clk_out_en_o <= 1'b0;
         trim_code_o  <= crs_pkg::TRIM_RST; // see [R7] [R8]
      end else if (wr_en && idx == crs_pkg::IDX_MCC) begin
         slow_sel_q   <= pwdata[crs_pkg::MCC_SLOW_BIT];
         clk_out_en_o <= pwdata[crs_pkg::MCC_CKO_BIT]; // see [R4]
      end else if (wr_en && idx == crs_pkg::IDX_TRIM) begin
         trim_code_o  <= pwdata[7:0];
      end
   end

   crs_slow_div #(
      .DIV        (crs_pkg::SLOW_DIV)
   ) u_slow_div (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .slow_sel_i (slow_sel_q),
      .cpu_en_o   (cpu_clk_en_o)
   );

   // ----------------------------------------
   // Supply integrity
   // ----------------------------------------

   // Thresholds follow the option; warning tracks the detector level
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         lvd_thresh_o <= 2'h0;
         avd_thresh_o <= 2'h0;
      end else begin
         lvd_thresh_o <= lvd_level_i; // see [R22]
         avd_thresh_o <= lvd_level_i;
      end
   end

   // Frozen during halt; set wins over a software clear
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         voltage_warning_flag_q    <= 1'b0;
         voltage_warning_irq_enable_q   <= 1'b0;
         low_voltage_reset_flag_q   <= 1'b0;
         watchdog_reset_flag_q   <= 1'b0;
         avd_irq_o <= 1'b0;
      end else if (!halt_i) begin // see [R26]
         voltage_warning_flag_q <= lvd_en_opt_i & avd_s_q; // see [R19] [R20]
         if (wr_en && idx == crs_pkg::IDX_SIR) begin
            voltage_warning_irq_enable_q <= pwdata[crs_pkg::SIR_VOLTAGE_WARNING_IRQ_ENABLE_BIT];
         end
         if (state_d == crs_pkg::ST_ACT && src_d == crs_pkg::SRC_LVD) begin
            low_voltage_reset_flag_q <= 1'b1; // see [R24]
         end else if (wr_en && idx == crs_pkg::IDX_SIR && !pwdata[crs_pkg::SIR_LOW_VOLTAGE_RESET_FLAG_BIT]) begin
            low_voltage_reset_flag_q <= 1'b0;
         end
         if (state_d == crs_pkg::ST_ACT && src_d == crs_pkg::SRC_LVD) begin
            watchdog_reset_flag_q <= 1'b0; // see [R18]
         end else if (state_q == crs_pkg::ST_RUN && state_d == crs_pkg::ST_ACT &&
                      src_d == crs_pkg::SRC_WDG) begin
            watchdog_reset_flag_q <= 1'b1;
         end else if (wr_en && idx == crs_pkg::IDX_RSF && !pwdata[crs_pkg::RSF_WDG_BIT]) begin
            watchdog_reset_flag_q <= 1'b0;
         end
         // A toggle in the acknowledge cycle still leaves the request pending
         if (voltage_warning_irq_enable_q && lvd_en_opt_i && (voltage_warning_flag_q != (lvd_en_opt_i & avd_s_q))) begin
            avd_irq_o <= 1'b1; // see [R21] [R25]
         end else if (irq_ack_i) begin
            avd_irq_o <= 1'b0;
         end
      end
   end

   // Wake only from wait; halt keeps the request from waking
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         avd_wake_o <= 1'b0;
      end else begin
         avd_wake_o <= avd_irq_o & ~halt_i; // see [R26]
      end
   end

   // ----------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      unique case (idx)
         crs_pkg::IDX_MCC:  rd_byte = {6'h00, clk_out_en_o, slow_sel_q}; // see [R3]
         crs_pkg::IDX_TRIM: rd_byte = trim_code_o;
         crs_pkg::IDX_SIR:  rd_byte = {4'h0, lock_q, low_voltage_reset_flag_q, voltage_warning_flag_q, voltage_warning_irq_enable_q};
         crs_pkg::IDX_RSF:  rd_byte = {7'h00, watchdog_reset_flag_q};
         default:           rd_hit  = 1'b0;
      endcase
   end

   // Answer is ready in the first access cycle
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~rd_hit;
         prdata  <= (psel & ~penable & ~pwrite & rd_hit) ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_fetch_two;
      vec_fetch_o [*2] ##1 !vec_fetch_o;
   endsequence

   AST_FETCH_TWO: assert property ($rose(vec_fetch_o) |-> s_fetch_two) // see [R12]
      else $error("vector fetch not two cycles");

   AST_FETCH_ADDR: assert property ($rose(vec_fetch_o) |-> vec_addr_o == 16'hFFFE ##1 vec_addr_o == 16'hFFFF) // see [R10]
      else $error("vector fetch address wrong");

   AST_DELAY_END: assert property (state_q == crs_pkg::ST_DELAY && cnt_q == 16'h00FF && !lvd_s_q
      |=> state_q == (pll_en_opt_i ? crs_pkg::ST_PLL : crs_pkg::ST_FETCH)) // see [R11]
      else $error("delay phase length wrong");

   AST_DELAY_PIN: assert property (state_q == crs_pkg::ST_DELAY |-> rst_pin_oe_o && !rst_pin_o) // see [R9]
      else $error("pin released during delay");

   AST_LVD_PIN: assert property (lvd_s_q |=> rst_pin_oe_o ##1 lvd_s_q |-> rst_pin_oe_o) // see [R17]
      else $error("pin not held during low voltage");

   AST_WDG_PULSE: assert property (state_q == crs_pkg::ST_RUN && wdg_underflow_i && !lvd_s_q
      |=> rst_pin_oe_o [*8]) // see [R16]
      else $error("watchdog pulse too short");

   AST_LVD_CLR_WDG: assert property (lvd_s_q && !halt_i |=> !watchdog_reset_flag_q && low_voltage_reset_flag_q) // see [R18]
      else $error("watchdog flag kept after low voltage");

   AST_CTRL_CLR: assert property (in_reset |=> !slow_sel_q && !clk_out_en_o && trim_code_o == 8'hFF) // see [R6]
      else $error("control not cleared in reset");

   AST_PLL_HOLD: assert property (pll_start |=> !pll_clk_en_o [*8]) // see [R1]
      else $error("pll clock released early");

   AST_AVD_GATE: assert property (!lvd_en_opt_i && !halt_i |=> !voltage_warning_flag_q) // see [R20]
      else $error("warning flag set with detector off");

   AST_AVD_IRQ: assert property (!halt_i && voltage_warning_irq_enable_q && lvd_en_opt_i && $changed(lvd_en_opt_i & avd_s_q)
      |=> avd_irq_o) // see [R21]
      else $error("toggle did not raise interrupt");

   AST_RSV_ZERO: assert property (pready && psel && !pwrite && idx == crs_pkg::IDX_MCC
      |-> prdata[7:2] == 6'h00) // see [R3]
      else $error("reserved bits not zero");

endmodule

// ==== verification/crs_reset_line.sv ====
// Model of the outside circuitry sharing the open-drain reset line
`timescale 1ns/100ps
module crs_reset_line (
   // Device side of the line
   input  wire logic rst_pin_o,
   input  wire logic rst_pin_oe_o,
   // Outside pull-down request
   input  wire logic ext_pull_i,
   // Resolved line level
   output logic      pin_o
);
   // Any party pulling low wins, otherwise the weak pull-up holds the line high
   assign pin_o = ~((rst_pin_oe_o & ~rst_pin_o) | ext_pull_i);
endmodule

// ==== verification/clock_reset_supervisor_bench.sv ====
// Self-checking bench for the clock and reset supervisor
`timescale 1ns/100ps
module clock_reset_supervisor_bench;
   // ----
   // Stimulus and observed signals
   // ----
   logic        core_clk_i = 1'b0;
   logic        rst_n_i, psel, penable, pwrite, ext_pull, rst_pin_i;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic        pready, pslverr, err_q, rst_pin_o, rst_pin_oe_o;
   logic        lvd_rst_i, wdg_underflow_i, pll_en_opt_i, lvd_en_opt_i, pll_lock_i, avd_cmp_i;
   logic [1:0]  lvd_level_i, lvd_thresh_o, avd_thresh_o;
   logic        halt_i, wake_i, irq_ack_i, core_rst_n_o, vec_fetch_o, cpu_clk_en_o;
   logic        pll_clk_en_o, clk_out_en_o, avd_irq_o, avd_wake_o;
   logic [15:0] vec_addr_o;
   logic [7:0]  trim_code_o;
   int          num_errors = 0;
   int          cmp_count  = 0;
   int          cyc = 0;
   int          n;
   localparam logic [7:0] A_MCC = {crs_pkg::IDX_MCC, 2'b00};
   localparam logic [7:0] A_TRIM = {crs_pkg::IDX_TRIM, 2'b00};
   localparam logic [7:0] A_SIR = {crs_pkg::IDX_SIR, 2'b00};
   localparam logic [7:0] A_RSF = {crs_pkg::IDX_RSF, 2'b00};
   localparam int WDG_LEN = crs_pkg::WDG_CYC + crs_pkg::DLY_CYC;

   always #50 core_clk_i = ~core_clk_i;

   crs_supervisor crs_supervisor_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
      .rst_pin_oe_o(rst_pin_oe_o), .lvd_rst_i(lvd_rst_i), .wdg_underflow_i(wdg_underflow_i),
      .pll_en_opt_i(pll_en_opt_i), .lvd_en_opt_i(lvd_en_opt_i), .lvd_level_i(lvd_level_i),
      .pll_lock_i(pll_lock_i), .avd_cmp_i(avd_cmp_i), .halt_i(halt_i), .wake_i(wake_i),
      .irq_ack_i(irq_ack_i), .core_rst_n_o(core_rst_n_o), .vec_fetch_o(vec_fetch_o),
      .vec_addr_o(vec_addr_o), .cpu_clk_en_o(cpu_clk_en_o), .pll_clk_en_o(pll_clk_en_o),
      .clk_out_en_o(clk_out_en_o), .trim_code_o(trim_code_o), .lvd_thresh_o(lvd_thresh_o),
      .avd_thresh_o(avd_thresh_o), .avd_irq_o(avd_irq_o), .avd_wake_o(avd_wake_o));

   crs_reset_line crs_reset_line_inst (.rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
      .ext_pull_i(ext_pull), .pin_o(rst_pin_i));

   // ----
   // Shared tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request stands until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      do @(posedge core_clk_i); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd_q & m, exp);
   endtask

   // Walks one reset sequence from the current cycle on, counting pin-driven and total cycles
   task automatic seq(input int exp_oe, input int exp_len);
      int n_oe, n_len, n_f;
      n_oe = 0;
      n_len = 0;
      n_f = 0;
      while (core_rst_n_o !== 1'b1 && n_len < 3000) begin
         n_len++;
         if (rst_pin_oe_o === 1'b1) n_oe++;
         if (vec_fetch_o === 1'b1) begin
            chk(vec_addr_o, crs_pkg::VEC_ADDR + n_f);
            n_f++;
         end
         @(negedge core_clk_i);
      end
      chk(n_f, crs_pkg::FETCH_CYC);
      if (exp_oe >= 0) chk(n_oe, exp_oe);
      else if (exp_oe == -1) chk(n_oe, n_len - 2);
      if (exp_len > 0) chk(n_len, exp_len);
   endtask

   task automatic wdg_pulse;
      @(posedge core_clk_i);
      wdg_underflow_i <= 1'b1;
      @(posedge core_clk_i);
      wdg_underflow_i <= 1'b0;
      @(negedge core_clk_i);
   endtask

   // Returns on a rising edge, so the next drive lands there and reads see settled values
   task automatic wait_cyc(input int k);
      repeat (k) @(posedge core_clk_i);
   endtask

   task automatic count_en(input int exp);
      n = 0;
      repeat (64) begin
         @(negedge core_clk_i);
         if (cpu_clk_en_o === 1'b1) n++;
      end
      chk(n, exp);
   endtask

   task automatic test_done;
      $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Cuts a hang short; the longest sequence is well below this
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end

   // ----
   // Test sequence
   // ----
   initial begin
      {rst_n_i, psel, penable, pwrite, ext_pull, lvd_rst_i, wdg_underflow_i} = '0;
      {pll_en_opt_i, lvd_en_opt_i, avd_cmp_i, halt_i, wake_i, irq_ack_i} = '0;
      pll_lock_i = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      lvd_level_i = 2'h0;
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(negedge core_clk_i);
      seq(crs_pkg::DLY_CYC, crs_pkg::DLY_CYC + crs_pkg::FETCH_CYC);
      rd_chk(A_MCC, 32'hFFFFFFFF, 32'h0);
      rd_chk(A_TRIM, 32'hFFFFFFFF, 32'hFF);
      rd_chk(A_SIR, 32'hFF, 32'h0);
      $display("test reset done");
      // Reserved bits, clock out, slow mode, trim, unmapped place
      apb(1'b1, A_MCC, 32'hFF);
      rd_chk(A_MCC, 32'hFFFFFFFF, 32'h3);
      chk(clk_out_en_o, 1'b1);
      wait_cyc(40);
      count_en(2);
      apb(1'b1, A_MCC, 32'h2);
      wait_cyc(40);
      count_en(64);
      apb(1'b1, A_TRIM, 32'h80);
      wait_cyc(1);
      chk(trim_code_o, 8'h80);
      apb(1'b0, 8'hF0, 32'h0);
      chk(rd_q, 32'h0);
      chk(err_q, 1'b1);
      for (int i = 0; i < 3; i++) begin
         lvd_level_i <= 2'(i);
         wait_cyc(3);
         chk({lvd_thresh_o, avd_thresh_o}, {2'(i), 2'(i)});
      end
      $display("test registers done");
      // Warning flag and interrupt, first with the detector option off
      apb(1'b1, A_SIR, 32'h1);
      avd_cmp_i <= 1'b1;
      wait_cyc(5);
      chk(avd_irq_o, 1'b0);
      avd_cmp_i <= 1'b0;
      lvd_en_opt_i <= 1'b1;
      wait_cyc(5);
      irq_ack_i <= 1'b1;
      @(posedge core_clk_i);
      irq_ack_i <= 1'b0;
      for (int i = 1; i >= 0; i--) begin
         avd_cmp_i <= 1'(i);
         wait_cyc(5);
         chk(avd_irq_o, 1'b1);
         chk(avd_wake_o, 1'b1);
         rd_chk(A_SIR, 32'h2, 32'(i) << 1);
         irq_ack_i <= 1'b1;
         @(posedge core_clk_i);
         irq_ack_i <= 1'b0;
         wait_cyc(2);
         chk(avd_irq_o, 1'b0);
      end
      // Halt freezes the flag, so a crossing neither requests nor wakes
      halt_i <= 1'b1;
      avd_cmp_i <= 1'b1;
      wait_cyc(6);
      chk({avd_irq_o, avd_wake_o}, 2'b00);
      halt_i <= 1'b0;
      $display("test warning done");
      // Watchdog reset clears clock control and trim
      wdg_pulse();
      seq(WDG_LEN, WDG_LEN + crs_pkg::FETCH_CYC);
      rd_chk(A_MCC, 32'hFF, 32'h0);
      rd_chk(A_TRIM, 32'hFF, 32'hFF);
      rd_chk(A_RSF, 32'h1, 32'h1);
      // Low-voltage reset after a watchdog reset
      lvd_rst_i <= 1'b1;
      wait_cyc(40);
      lvd_rst_i <= 1'b0;
      chk(rst_pin_oe_o, 1'b1);
      seq(-1, 0);
      rd_chk(A_SIR, 32'h4, 32'h4);
      rd_chk(A_RSF, 32'h1, 32'h0);
      apb(1'b1, A_SIR, 32'h0);
      rd_chk(A_SIR, 32'h4, 32'h0);
      $display("test watchdog and low voltage done");
      // Outside pull on the reset line
      ext_pull <= 1'b1;
      wait_cyc(6);
      chk(core_rst_n_o, 1'b0);
      ext_pull <= 1'b0;
      seq(crs_pkg::DLY_CYC, 0);
      $display("test external reset done");
      // PLL start-up delay adds to the sequence; a wake restarts it
      wait_cyc(1);
      pll_en_opt_i <= 1'b1;
      wdg_pulse();
      seq(-2, WDG_LEN + crs_pkg::PLL_CYC + crs_pkg::FETCH_CYC);
      chk(pll_clk_en_o, 1'b1);
      rd_chk(A_SIR, 32'h8, 32'h8);
      wake_i <= 1'b1;
      wait_cyc(1);
      wake_i <= 1'b0;
      wait_cyc(2);
      chk(pll_clk_en_o, 1'b0);
      $display("test pll done");
      test_done();
   end
endmodule
